// *** common/fifo_flags_pkg.sv ***
// Shared constants, types and pin bundles for the two-port flag FIFO.
package fifo_flags_pkg;

    localparam int DATA_W = 36;
    localparam int FIFO_DEPTH = 16;
    localparam int WORD_W = 18;
    localparam int BYTE_W = 9;

    localparam int CLK_PERIOD_NS = 25;
    localparam int RTR_NS = 90;
    localparam int RTR_CYCLES = (RTR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FLAG_SETTLE_CYCLES = 2;

    localparam logic FULL_N_RST = 1'b1;
    localparam logic EMPTY_N_RST = 1'b0;
    localparam logic ALMOST_FULL_N_RST = 1'b1;
    localparam logic ALMOST_EMPTY_N_RST = 1'b0;
    localparam logic MAILBOX_FULL_N_RST = 1'b1;

    typedef enum logic [1:0] {
        SIZE_LONG,
        SIZE_WORD,
        SIZE_BYTE
    } bus_size_t;

    typedef struct packed {
        logic write_port_clock;
        logic read_port_clock;
        logic port_a_select_n;
        logic port_a_direction;
        logic port_a_mailbox_select;
        logic port_b_select_n;
        logic port_b_direction;
        logic port_b_mailbox_select;
        logic retransmit_request_n;
        logic [DATA_W-1:0] port_a_data;
        logic [DATA_W-1:0] port_b_data;
    } pins_t;

    // Idle pin levels: deselected ports and no retransmit request, so release shows no false edge.
    localparam pins_t PINS_RST = '{
        write_port_clock: 1'b0,
        read_port_clock: 1'b0,
        port_a_select_n: 1'b1,
        port_a_direction: 1'b0,
        port_a_mailbox_select: 1'b0,
        port_b_select_n: 1'b1,
        port_b_direction: 1'b0,
        port_b_mailbox_select: 1'b0,
        retransmit_request_n: 1'b1,
        port_a_data: '0,
        port_b_data: '0
    };

    typedef struct packed {
        logic full_flag_n;
        logic almost_full_n;
        logic empty_flag_n;
        logic almost_empty_n;
        logic a_to_b_mailbox_full_n;
        logic b_to_a_mailbox_full_n;
    } flags_t;

endpackage : fifo_flags_pkg

// *** rtl/word_fifo.sv ***
// Parameterised single-clock FIFO storage with rewind for retransmit.
`timescale 1ns/1ps
module word_fifo #(
    parameter int WIDTH = 36,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // Drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o,
    // Read pointer back to the start of the stored run
    input wire logic rewind_i
);

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr_r;
    logic [AW:0] rd_ptr_r;
    wire [AW:0] count = wr_ptr_r - rd_ptr_r;
    wire push = in_valid_i & in_ready_o;
    wire pop = out_valid_o & out_ready_i & ~rewind_i;

    assign in_ready_o = (count != (AW+1)'(DEPTH));
    assign out_valid_o = (count != '0);
    assign out_data_o = mem[rd_ptr_r[AW-1:0]];

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr_r[AW-1:0]] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (rewind_i) begin
                // Stored run starts at zero only while it has never wrapped.
                rd_ptr_r <= '0;
            end else if (pop) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
        end
    end

endmodule : word_fifo

// *** rtl/flag_fifo.sv ***
// Two-port FIFO with bus matching, skewed flags, mailboxes and retransmit.
`timescale 1ns/1ps
module flag_fifo #(
    parameter int DEPTH = fifo_flags_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Port clocks and strobes from the pins
    input wire logic write_port_clock_i,
    input wire logic read_port_clock_i,
    input wire logic port_a_select_n_i,
    input wire logic port_a_direction_i,
    input wire logic port_a_mailbox_select_i,
    input wire logic port_b_select_n_i,
    input wire logic port_b_direction_i,
    input wire logic port_b_mailbox_select_i,
    input wire logic retransmit_request_n_i,
    // Static configuration
    input wire fifo_flags_pkg::bus_size_t port_b_size_i,
    input wire logic fall_through_mode_i,
    input wire logic [$clog2(DEPTH):0] almost_full_offset_i,
    input wire logic [$clog2(DEPTH):0] almost_empty_offset_i,
    // Port A data pins
    input wire logic [fifo_flags_pkg::DATA_W-1:0] port_a_data_i,
    output logic [fifo_flags_pkg::DATA_W-1:0] port_a_data_o,
    output logic port_a_data_oe_n_o,
    // Port B data pins
    input wire logic [fifo_flags_pkg::DATA_W-1:0] port_b_data_i,
    output logic [fifo_flags_pkg::DATA_W-1:0] port_b_data_o,
    output logic port_b_data_oe_n_o,
    // Flags
    output logic full_flag_n_o,
    output logic almost_full_n_o,
    output logic empty_flag_n_o,
    output logic almost_empty_n_o,
    output logic a_to_b_mailbox_full_n_o,
    output logic b_to_a_mailbox_full_n_o,
    output logic retransmit_busy_o
);

    localparam int DW = fifo_flags_pkg::DATA_W;
    localparam int CW = $clog2(DEPTH) + 1;
    localparam int RCW = 4;

    // Keeps only the lanes that the configured read-port width carries.
    function automatic logic [DW-1:0] mask_by_size(input logic [DW-1:0] d, input fifo_flags_pkg::bus_size_t s);
        case (s)
            fifo_flags_pkg::SIZE_WORD: mask_by_size = {{(DW-fifo_flags_pkg::WORD_W){1'b0}}, d[fifo_flags_pkg::WORD_W-1:0]};
            fifo_flags_pkg::SIZE_BYTE: mask_by_size = {{(DW-fifo_flags_pkg::BYTE_W){1'b0}}, d[fifo_flags_pkg::BYTE_W-1:0]};
            default: mask_by_size = d;
        endcase
    endfunction : mask_by_size

    // All pin inputs pass two flip-flops together so they stay aligned.
    fifo_flags_pkg::pins_t pins_now;
    fifo_flags_pkg::pins_t pins_s1_r;
    fifo_flags_pkg::pins_t pins_s2_r;
    logic wclk_d_r;
    logic rclk_d_r;
    logic rt_req_d_r;

    assign pins_now = '{
        write_port_clock: write_port_clock_i,
        read_port_clock: read_port_clock_i,
        port_a_select_n: port_a_select_n_i,
        port_a_direction: port_a_direction_i,
        port_a_mailbox_select: port_a_mailbox_select_i,
        port_b_select_n: port_b_select_n_i,
        port_b_direction: port_b_direction_i,
        port_b_mailbox_select: port_b_mailbox_select_i,
        retransmit_request_n: retransmit_request_n_i,
        port_a_data: port_a_data_i,
        port_b_data: port_b_data_i
    };

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            // Resetting to idle pin levels keeps the retransmit edge detector quiet at release.
            pins_s1_r <= fifo_flags_pkg::PINS_RST;
            pins_s2_r <= fifo_flags_pkg::PINS_RST;
            wclk_d_r <= 1'b0;
            rclk_d_r <= 1'b0;
            rt_req_d_r <= 1'b1;
        end else begin
            pins_s1_r <= pins_now;
            pins_s2_r <= pins_s1_r;
            wclk_d_r <= pins_s2_r.write_port_clock;
            rclk_d_r <= pins_s2_r.read_port_clock;
            rt_req_d_r <= pins_s2_r.retransmit_request_n;
        end
    end

    wire wr_edge = pins_s2_r.write_port_clock & ~wclk_d_r;
    wire rd_edge = pins_s2_r.read_port_clock & ~rclk_d_r;
    wire a_sel = ~pins_s2_r.port_a_select_n;
    wire b_sel = ~pins_s2_r.port_b_select_n;

    fifo_flags_pkg::flags_t flags_r;
    fifo_flags_pkg::flags_t flags_nxt;
    logic [RCW-1:0] rt_cnt_r;
    wire rt_busy = (rt_cnt_r != '0);
    wire rt_start = rt_req_d_r & ~pins_s2_r.retransmit_request_n & ~fall_through_mode_i & ~rt_busy;

    // FIFO access strobes; mailbox select steers to the mailboxes instead.
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [DW-1:0] fifo_out_data;
    wire wr_fire = wr_edge & a_sel & pins_s2_r.port_a_direction & ~pins_s2_r.port_a_mailbox_select
                   & flags_r.full_flag_n & fifo_in_ready & ~rt_busy;
    wire rd_fire = rd_edge & b_sel & pins_s2_r.port_b_direction & ~pins_s2_r.port_b_mailbox_select
                   & flags_r.empty_flag_n & fifo_out_valid & ~rt_busy;

    // Bus matching: a long word leaves the store only with its last lane.
    logic [1:0] lane_r;
    wire [1:0] last_lane = (port_b_size_i == fifo_flags_pkg::SIZE_BYTE) ? 2'h3 :
                           (port_b_size_i == fifo_flags_pkg::SIZE_WORD) ? 2'h1 : 2'h0;
    wire pop = rd_fire & (lane_r == last_lane);
    wire [DW-1:0] lane_shifted = (port_b_size_i == fifo_flags_pkg::SIZE_WORD)
                                 ? (fifo_out_data >> (lane_r[0] * fifo_flags_pkg::WORD_W))
                                 : (fifo_out_data >> (lane_r * fifo_flags_pkg::BYTE_W));
    wire [DW-1:0] lane_data = mask_by_size(lane_shifted, port_b_size_i);

    word_fifo #(
        .WIDTH(DW),
        .DEPTH(DEPTH)
    ) u_store (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .in_valid_i(wr_fire),
        .in_ready_o(fifo_in_ready),
        .in_data_i(pins_s2_r.port_a_data),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(pop),
        .out_data_o(fifo_out_data),
        .rewind_i(rt_start)
    );

    // Occupancy seen by each port, with the far pointer two stages late.
    logic [CW-1:0] wr_cnt_r;
    logic [CW-1:0] rd_cnt_r;
    logic [CW-1:0] wr_cnt_s1_r;
    logic [CW-1:0] wr_cnt_s2_r;
    logic [CW-1:0] rd_cnt_s1_r;
    logic [CW-1:0] rd_cnt_s2_r;
    wire [CW-1:0] wr_cnt_nxt = wr_fire ? wr_cnt_r + 1'b1 : wr_cnt_r;
    wire [CW-1:0] rd_cnt_nxt = rt_start ? '0 : (pop ? rd_cnt_r + 1'b1 : rd_cnt_r);
    wire [CW-1:0] occ_w = rt_busy ? (wr_cnt_r - rd_cnt_r) : (wr_cnt_nxt - rd_cnt_s2_r);
    wire [CW-1:0] occ_r = rt_busy ? (wr_cnt_r - rd_cnt_r) : (wr_cnt_s2_r - rd_cnt_nxt);
    wire [CW-1:0] af_level = CW'(DEPTH) - almost_full_offset_i;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_cnt_r <= '0;
            rd_cnt_r <= '0;
            wr_cnt_s1_r <= '0;
            wr_cnt_s2_r <= '0;
            rd_cnt_s1_r <= '0;
            rd_cnt_s2_r <= '0;
        end else begin
            wr_cnt_r <= wr_cnt_nxt;
            rd_cnt_r <= rd_cnt_nxt;
            wr_cnt_s1_r <= wr_cnt_r;
            wr_cnt_s2_r <= wr_cnt_s1_r;
            rd_cnt_s1_r <= rd_cnt_r;
            rd_cnt_s2_r <= rd_cnt_s1_r;
        end
    end

    // Mailboxes: a set on one side wins over a clear from the other side.
    logic [DW-1:0] a_to_b_mailbox_r;
    logic [DW-1:0] b_to_a_mailbox_r;
    wire a_mb_wr = wr_edge & a_sel & pins_s2_r.port_a_direction & pins_s2_r.port_a_mailbox_select
                   & flags_r.a_to_b_mailbox_full_n;
    wire b_mb_rd = rd_edge & b_sel & pins_s2_r.port_b_direction & pins_s2_r.port_b_mailbox_select;
    wire b_mb_wr = rd_edge & b_sel & ~pins_s2_r.port_b_direction & pins_s2_r.port_b_mailbox_select
                   & flags_r.b_to_a_mailbox_full_n;
    wire a_mb_rd = wr_edge & a_sel & ~pins_s2_r.port_a_direction & pins_s2_r.port_a_mailbox_select;

    always_comb begin
        flags_nxt = flags_r;
        // Write-side flags move only on write-port edges, or every cycle while retransmit settles.
        if (wr_edge | rt_busy) begin
            flags_nxt.full_flag_n = (occ_w < CW'(DEPTH));
            flags_nxt.almost_full_n = (occ_w < af_level);
        end
        if (rd_edge | rt_busy) begin
            flags_nxt.empty_flag_n = (occ_r != '0);
            flags_nxt.almost_empty_n = (occ_r > almost_empty_offset_i);
        end
        if (a_mb_wr) begin
            flags_nxt.a_to_b_mailbox_full_n = 1'b0;
        end else if (b_mb_rd) begin
            flags_nxt.a_to_b_mailbox_full_n = 1'b1;
        end
        if (b_mb_wr) begin
            flags_nxt.b_to_a_mailbox_full_n = 1'b0;
        end else if (a_mb_rd) begin
            flags_nxt.b_to_a_mailbox_full_n = 1'b1;
        end
    end

    logic [DW-1:0] rd_data_r;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            flags_r <= '{
                full_flag_n: fifo_flags_pkg::FULL_N_RST,
                almost_full_n: fifo_flags_pkg::ALMOST_FULL_N_RST,
                empty_flag_n: fifo_flags_pkg::EMPTY_N_RST,
                almost_empty_n: fifo_flags_pkg::ALMOST_EMPTY_N_RST,
                a_to_b_mailbox_full_n: fifo_flags_pkg::MAILBOX_FULL_N_RST,
                b_to_a_mailbox_full_n: fifo_flags_pkg::MAILBOX_FULL_N_RST
            };
            a_to_b_mailbox_r <= '0;
            b_to_a_mailbox_r <= '0;
            rd_data_r <= '0;
            lane_r <= '0;
            rt_cnt_r <= '0;
        end else begin
            flags_r <= flags_nxt;
            if (a_mb_wr) begin
                a_to_b_mailbox_r <= mask_by_size(pins_s2_r.port_a_data, port_b_size_i);
            end
            if (b_mb_wr) begin
                b_to_a_mailbox_r <= mask_by_size(pins_s2_r.port_b_data, port_b_size_i);
            end
            if (rt_start) begin
                lane_r <= '0;
            end else if (rd_fire) begin
                rd_data_r <= lane_data;
                lane_r <= pop ? 2'h0 : lane_r + 1'b1;
            end
            if (rt_start) begin
                // Recovery time first, then the settling cycles for the almost flags.
                rt_cnt_r <= RCW'(fifo_flags_pkg::RTR_CYCLES + fifo_flags_pkg::FLAG_SETTLE_CYCLES);
            end else if (rt_busy) begin
                rt_cnt_r <= rt_cnt_r - 1'b1;
            end
        end
    end

    // Data pins drive while selected in the read direction of each port.
    assign port_a_data_o = b_to_a_mailbox_r;
    assign port_a_data_oe_n_o = ~(a_sel & ~pins_s2_r.port_a_direction);
    assign port_b_data_o = pins_s2_r.port_b_mailbox_select ? a_to_b_mailbox_r : rd_data_r;
    assign port_b_data_oe_n_o = ~(b_sel & pins_s2_r.port_b_direction);

    assign full_flag_n_o = flags_r.full_flag_n;
    assign almost_full_n_o = flags_r.almost_full_n;
    assign empty_flag_n_o = flags_r.empty_flag_n;
    assign almost_empty_n_o = flags_r.almost_empty_n;
    assign a_to_b_mailbox_full_n_o = flags_r.a_to_b_mailbox_full_n;
    assign b_to_a_mailbox_full_n_o = flags_r.b_to_a_mailbox_full_n;
    assign retransmit_busy_o = rt_busy;

endmodule : flag_fifo

// *** verif/flag_fifo_asserts.sv ***
// Port-level flag, mailbox and retransmit timing checks for the two-port flag FIFO.
`timescale 1ns/1ps
module flag_fifo_asserts (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Pins
    input wire logic write_port_clock_i,
    input wire logic read_port_clock_i,
    input wire logic port_a_select_n_i,
    input wire logic port_a_direction_i,
    input wire logic port_a_mailbox_select_i,
    input wire logic port_b_select_n_i,
    input wire logic port_b_direction_i,
    input wire logic port_b_mailbox_select_i,
    input wire fifo_flags_pkg::bus_size_t port_b_size_i,
    // Outputs
    input wire logic [fifo_flags_pkg::DATA_W-1:0] port_b_data_o,
    input wire logic full_flag_n_o,
    input wire logic almost_full_n_o,
    input wire logic empty_flag_n_o,
    input wire logic almost_empty_n_o,
    input wire logic a_to_b_mailbox_full_n_o,
    input wire logic b_to_a_mailbox_full_n_o,
    input wire logic retransmit_busy_o,
    input wire logic port_a_data_oe_n_o,
    input wire logic port_b_data_oe_n_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // Flags are recomputed freely during retransmit, so edge ownership is checked outside it.
    logic busy_r;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            busy_r <= 1'b0;
        end else begin
            busy_r <= retransmit_busy_o;
        end
    end
    wire logic quiet = !retransmit_busy_o && !busy_r;

    a_full_write_edge: assert property (
        $changed(full_flag_n_o) && quiet |-> $past(write_port_clock_i, 2))
        else $error("full flag moved off a write edge");
    a_afull_write_edge: assert property (
        $changed(almost_full_n_o) && quiet |-> $past(write_port_clock_i, 2))
        else $error("almost-full flag moved off a write edge");
    a_empty_read_edge: assert property (
        $changed(empty_flag_n_o) && quiet |-> $past(read_port_clock_i, 2))
        else $error("empty flag moved off a read edge");
    a_aempty_read_edge: assert property (
        $changed(almost_empty_n_o) && quiet |-> $past(read_port_clock_i, 2))
        else $error("almost-empty flag moved off a read edge");
    a_word_upper_zero: assert property (
        (!port_b_mailbox_select_i)[*4] ##0 (port_b_size_i == fifo_flags_pkg::SIZE_WORD)
        |-> port_b_data_o[35:18] == 18'h0)
        else $error("word read upper half not zero");
    a_byte_upper_zero: assert property (
        (!port_b_mailbox_select_i)[*4] ##0 (port_b_size_i == fifo_flags_pkg::SIZE_BYTE)
        |-> port_b_data_o[35:9] == 27'h0)
        else $error("byte read upper lanes not zero");
    a_mbox_ab_set: assert property (
        $fell(a_to_b_mailbox_full_n_o) |-> $past(write_port_clock_i, 2) && $past(port_a_mailbox_select_i, 2))
        else $error("A-to-B mailbox filled without a mailbox write");
    a_mbox_ba_set: assert property (
        $fell(b_to_a_mailbox_full_n_o)
        |-> $past(read_port_clock_i, 2) && $past(port_b_mailbox_select_i, 2) && !$past(port_b_direction_i, 2))
        else $error("B-to-A mailbox filled without a mailbox write");
    a_rt_busy_len: assert property (
        $rose(retransmit_busy_o) |-> retransmit_busy_o[*6] ##1 !retransmit_busy_o)
        else $error("retransmit recovery window has the wrong length");
    a_porta_drive_en: assert property (
        port_a_data_oe_n_o == !(!$past(port_a_select_n_i, 2) && !$past(port_a_direction_i, 2)))
        else $error("port A drive enable does not follow select and direction");
    a_portb_drive_en: assert property (
        port_b_data_oe_n_o == !(!$past(port_b_select_n_i, 2) && $past(port_b_direction_i, 2)))
        else $error("port B drive enable does not follow select and direction");
endmodule : flag_fifo_asserts

bind flag_fifo flag_fifo_asserts u_flag_fifo_asserts (
    .clk_i(clk_i), .rst_i(rst_i), .write_port_clock_i(write_port_clock_i),
    .read_port_clock_i(read_port_clock_i), .port_a_mailbox_select_i(port_a_mailbox_select_i),
    .port_b_direction_i(port_b_direction_i), .port_b_mailbox_select_i(port_b_mailbox_select_i),
    .port_b_size_i(port_b_size_i), .port_b_data_o(port_b_data_o), .full_flag_n_o(full_flag_n_o),
    .almost_full_n_o(almost_full_n_o), .empty_flag_n_o(empty_flag_n_o), .almost_empty_n_o(almost_empty_n_o),
    .a_to_b_mailbox_full_n_o(a_to_b_mailbox_full_n_o), .b_to_a_mailbox_full_n_o(b_to_a_mailbox_full_n_o),
    .retransmit_busy_o(retransmit_busy_o), .port_a_select_n_i(port_a_select_n_i),
    .port_a_direction_i(port_a_direction_i), .port_b_select_n_i(port_b_select_n_i),
    .port_a_data_oe_n_o(port_a_data_oe_n_o), .port_b_data_oe_n_o(port_b_data_oe_n_o)
);

// *** verif/port_host_model.sv ***
// Host model: free-running port clocks and strobed accesses on both ports.
`timescale 1ns/1ps
module port_host_model (
    // Clock
    input wire logic clk_i,
    // Data returned by the device
    input wire logic [fifo_flags_pkg::DATA_W-1:0] a_read_data_i,
    input wire logic [fifo_flags_pkg::DATA_W-1:0] b_read_data_i,
    // Pins driven into the device
    output fifo_flags_pkg::pins_t pins_o
);
    logic [2:0] a_cnt;
    logic [2:0] b_cnt;

    initial begin
        a_cnt = 3'h0;
        b_cnt = 3'h0;
        pins_o = '0;
        pins_o.port_a_select_n = 1'b1;
        pins_o.port_b_select_n = 1'b1;
        pins_o.retransmit_request_n = 1'b1;
    end

    // Both port clocks run at all times: the write clock every 6 and the read clock every 8 clk_i cycles.
    always @(posedge clk_i) begin
        a_cnt <= (a_cnt == 3'h5) ? 3'h0 : a_cnt + 3'h1;
        b_cnt <= b_cnt + 3'h1;
        pins_o.write_port_clock <= (a_cnt < 3'h3);
        pins_o.read_port_clock <= b_cnt[2];
    end

    task automatic wait_pin(input bit on_b, input logic lvl);
        do @(posedge clk_i);
        while ((on_b ? pins_o.read_port_clock : pins_o.write_port_clock) !== lvl);
    endtask : wait_pin

    // Strobes change just after a port clock fall and hold to the next fall, so the
    // synchronised edge always finds them settled.
    task automatic port_cycle(input bit on_b, input logic dir, input logic mb,
            input logic [35:0] d, output logic [35:0] q);
        wait_pin(on_b, 1'b1);
        wait_pin(on_b, 1'b0);
        if (on_b) begin
            {pins_o.port_b_select_n, pins_o.port_b_direction, pins_o.port_b_mailbox_select} <= {1'b0, dir, mb};
            pins_o.port_b_data <= d;
        end else begin
            {pins_o.port_a_select_n, pins_o.port_a_direction, pins_o.port_a_mailbox_select} <= {1'b0, dir, mb};
            pins_o.port_a_data <= d;
        end
        wait_pin(on_b, 1'b1);
        wait_pin(on_b, 1'b0);
        // Released data lines show the inverse, so a stale value cannot pass for a held one.
        if (on_b) begin
            pins_o.port_b_select_n <= 1'b1;
            pins_o.port_b_data <= ~d;
        end else begin
            pins_o.port_a_select_n <= 1'b1;
            pins_o.port_a_data <= ~d;
        end
        @(posedge clk_i);
        q = on_b ? b_read_data_i : a_read_data_i;
    endtask : port_cycle

    // The request falls right after a write clock fall, with no write in that cycle.
    task automatic retransmit();
        wait_pin(1'b0, 1'b1);
        wait_pin(1'b0, 1'b0);
        pins_o.retransmit_request_n <= 1'b0;
        repeat (4) @(posedge clk_i);
        pins_o.retransmit_request_n <= 1'b1;
    endtask : retransmit
endmodule : port_host_model

// *** verif/flag_fifo_tb_top.sv ***
// Self-checking bench for the two-port flag FIFO.
`timescale 1ns/1ps
module flag_fifo_tb_top;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    fifo_flags_pkg::bus_size_t port_b_size_i = fifo_flags_pkg::SIZE_LONG;
    fifo_flags_pkg::pins_t pins;
    fifo_flags_pkg::flags_t flags;
    logic [35:0] a_data;
    logic [35:0] b_data;
    logic [35:0] v;
    logic busy;
    int num_errors = 0;
    int total_checks = 0;
    int cycles = 0;

    always #12.5 clk_i = ~clk_i;

    flag_fifo u_flag_fifo (
        .clk_i(clk_i), .rst_i(rst_i), .write_port_clock_i(pins.write_port_clock),
        .read_port_clock_i(pins.read_port_clock), .port_a_select_n_i(pins.port_a_select_n),
        .port_a_direction_i(pins.port_a_direction), .port_a_mailbox_select_i(pins.port_a_mailbox_select),
        .port_b_select_n_i(pins.port_b_select_n), .port_b_direction_i(pins.port_b_direction),
        .port_b_mailbox_select_i(pins.port_b_mailbox_select), .retransmit_request_n_i(pins.retransmit_request_n),
        .port_b_size_i(port_b_size_i), .fall_through_mode_i(1'b0), .almost_full_offset_i(5'h02),
        .almost_empty_offset_i(5'h02), .port_a_data_i(pins.port_a_data), .port_a_data_o(a_data),
        .port_a_data_oe_n_o(), .port_b_data_i(pins.port_b_data), .port_b_data_o(b_data),
        .port_b_data_oe_n_o(), .full_flag_n_o(flags.full_flag_n), .almost_full_n_o(flags.almost_full_n),
        .empty_flag_n_o(flags.empty_flag_n), .almost_empty_n_o(flags.almost_empty_n),
        .a_to_b_mailbox_full_n_o(flags.a_to_b_mailbox_full_n),
        .b_to_a_mailbox_full_n_o(flags.b_to_a_mailbox_full_n), .retransmit_busy_o(busy)
    );

    port_host_model u_port_host_model (
        .clk_i(clk_i), .a_read_data_i(a_data), .b_read_data_i(b_data), .pins_o(pins)
    );

    task automatic test_done();
        $display("Checks %0d, mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : test_done

    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors = num_errors + 1;
            test_done();
        end
    end

    task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
        total_checks = total_checks + 1;
        if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    function automatic logic [35:0] val(input int i);
        return 36'(i) * 36'h0_1357_9bdf + 36'h8_0000_0001;
    endfunction : val

    task automatic restart(input fifo_flags_pkg::bus_size_t size);
        @(posedge clk_i);
        rst_i <= 1'b1;
        port_b_size_i <= size;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
    endtask : restart

    // Cross-domain flags land within two periods of the slower port clock.
    task automatic settle();
        repeat (20) @(posedge clk_i);
    endtask : settle

    task automatic wr(input logic [35:0] d);
        logic [35:0] q;
        u_port_host_model.port_cycle(1'b0, 1'b1, 1'b0, d, q);
    endtask : wr

    task automatic rd(input logic [35:0] exp);
        logic [35:0] q;
        u_port_host_model.port_cycle(1'b1, 1'b1, 1'b0, 36'h0, q);
        chk(q, exp);
    endtask : rd

    task automatic wait_busy(input logic lvl);
        int n;
        n = 0;
        while (busy !== lvl && n < 40) begin
            @(posedge clk_i);
            n++;
        end
        chk(busy, lvl);
    endtask : wait_busy

    // Each mailbox is written, then read in a later access, never both at once.
    task automatic mbox(input logic [35:0] mask);
        logic [35:0] q;
        u_port_host_model.port_cycle(1'b0, 1'b1, 1'b1, 36'ha_5c3c_96e1, q);
        chk(flags.a_to_b_mailbox_full_n, 36'h0);
        u_port_host_model.port_cycle(1'b1, 1'b1, 1'b1, 36'h0, q);
        chk(q & mask, 36'ha_5c3c_96e1 & mask);
        u_port_host_model.port_cycle(1'b1, 1'b0, 1'b1, 36'h5_a3c3_691e, q);
        chk(flags.b_to_a_mailbox_full_n, 36'h0);
        u_port_host_model.port_cycle(1'b0, 1'b0, 1'b1, 36'h0, q);
        chk(q & mask, 36'h5_a3c3_691e & mask);
        chk({flags.a_to_b_mailbox_full_n, flags.b_to_a_mailbox_full_n}, 36'h3);
    endtask : mbox

    initial begin
        restart(fifo_flags_pkg::SIZE_LONG);
        chk(flags, 36'h33);
        for (int i = 0; i < 17; i++) begin
            wr(val(i));
        end
        settle();
        chk(flags, 36'h0f);
        for (int i = 0; i < 3; i++) begin
            rd(val(i));
        end
        settle();
        chk(flags, 36'h3f);
        for (int i = 3; i < 16; i++) begin
            rd(val(i));
        end
        settle();
        chk(flags, 36'h33);
        mbox(36'hf_ffff_ffff);
        restart(fifo_flags_pkg::SIZE_WORD);
        for (int i = 0; i < 3; i++) begin
            wr(val(i));
        end
        settle();
        v = val(0);
        for (int k = 0; k < 2; k++) begin
            rd(36'(v[18*k +: 18]));
            chk(flags.almost_empty_n, (k == 0) ? 36'h1 : 36'h0);
        end
        u_port_host_model.retransmit();
        wait_busy(1'b1);
        wait_busy(1'b0);
        chk(flags, 36'h3f);
        rd(36'(v[17:0]));
        mbox(36'h0_0003_ffff);
        restart(fifo_flags_pkg::SIZE_BYTE);
        wr(val(5));
        // The empty flag must see the write on a read edge before the first read is taken.
        settle();
        v = val(5);
        for (int k = 0; k < 4; k++) begin
            rd(36'(v[9*k +: 9]));
        end
        mbox(36'h0_0000_01ff);
        test_done();
    end
endmodule : flag_fifo_tb_top
